/* hdl/esr_ctrl.sv */
// exception state and reset control registers behind an AXI4-Lite slave
// Functional notes
// - writing 1 to timer_clear_pending clears timer pending, 0 does nothing.
// - timer_clear_pending is write-only and its read value is not defined.
// - any_interrupt_pending reads 1 while a peripheral interrupt pends.
// - top_pending_exception_number gives the best pending enabled one, else 0.
// - active_exception_number is the core's exception field, 0 in thread mode.
// - active exception number minus sixteen is the peripheral interrupt index.
// - a reset control write acts only when its upper half holds the key.
// - data_byte_order reads 0 for little-endian and 1 for big-endian.
// - a keyed write of 1 to system_reset_request requests reset, reads 0.
// - debug_active_clear always reads as 0.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "esr_consts.svh"

module esr_ctrl
  import esr_pkg::*;
#(
  parameter bit BIG_ENDIAN = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire esr_core_s core,
  output logic timer_pending,
  output logic [5:0] active_irq_index,
  output logic active_irq_valid,
  output logic sys_reset_req,
  output logic irq
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // lowest exception number wins among the pending enabled sources
  function automatic logic [5:0] top_pending(
    input logic tmr,
    input logic [`ESR_NIRQ-1:0] pend
  );
    logic [5:0] n;
    n = 6'h00;
    for (int i = `ESR_NIRQ - 1; i >= 0; i--) begin
      if (pend[i]) begin
        n = 6'(`ESR_IRQ_BASE + 6'(i));
      end
    end
    if (tmr) begin
      n = `ESR_TIMER_EXC;
    end
    return n;
  endfunction : top_pending

  esr_wstate_e wstate_q, wstate_d;
  esr_rstate_e rstate_q, rstate_d;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic timer_q, timer_d, rst_req_q, irq_q;
  logic [5:0] irq_index_q;
  logic irq_valid_q;
  logic [`ESR_EV_W-1:0] status_q, status_d, mask_q, mask_d, events;

  // write channel decode
  wire wr_fire = s_axi_awvalid & awready_q & s_axi_wvalid & wready_q;
  wire [5:0] wr_idx = s_axi_awaddr[7:2];
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd = s_axi_wdata & wmask;
  wire wr_ctrl_state = wr_fire & (wr_idx == `ESR_CTRL_STATE_IDX);
  wire wr_rst_ctrl = wr_fire & (wr_idx == `ESR_RST_CTRL_IDX);
  wire wr_mask = wr_fire & (wr_idx == `ESR_MASK_IDX);
  wire wr_hit = wr_ctrl_state | wr_rst_ctrl | wr_mask |
                (wr_idx == `ESR_STATUS_IDX);
  wire key_ok = (wd[31:`ESR_KEY_LSB] == `ESR_KEY);
  wire tmr_set_wr = wr_ctrl_state & wd[`ESR_TMR_SET_BIT];
  wire tmr_clr_wr = wr_ctrl_state & wd[`ESR_TMR_CLR_BIT];
  wire rst_req_d = wr_rst_ctrl & key_ok & wd[`ESR_RST_REQ_BIT];
  wire key_bad = wr_rst_ctrl & ~key_ok;

  // read channel decode
  wire rd_fire = s_axi_arvalid & arready_q;
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire rd_status = rd_fire & (rd_idx == `ESR_STATUS_IDX);

  // exception state as software sees it
  wire any_pend = |core.ext_pending;
  wire [5:0] top_num =
    top_pending(timer_q, core.ext_pending & core.ext_enable);
  wire [5:0] active_num = core.active_number;

  // clear-pending and reserved bits read as zero
  wire [31:0] ctrl_state_rd = {5'h00, timer_q, 1'b0, 2'h0, any_pend,
    4'h0, top_num, 6'h00, active_num};
  // key half, request and debug bits read as zero
  wire [31:0] rst_ctrl_rd = {16'h0000, BIG_ENDIAN, 12'h000,
    3'h0};
  wire rd_hit = (rd_idx == `ESR_CTRL_STATE_IDX) |
                (rd_idx == `ESR_RST_CTRL_IDX) |
                (rd_idx == `ESR_STATUS_IDX) | (rd_idx == `ESR_MASK_IDX);
  wire [31:0] rd_word =
    (rd_idx == `ESR_CTRL_STATE_IDX) ? ctrl_state_rd :
    (rd_idx == `ESR_RST_CTRL_IDX) ? rst_ctrl_rd :
    (rd_idx == `ESR_STATUS_IDX) ? {29'h0, status_q} :
    (rd_idx == `ESR_MASK_IDX) ? {29'h0, mask_q} : 32'h0000_0000;

  // set wins over clear, both for the timer event and for the timer set bit
  assign timer_d = core.timer_event | tmr_set_wr |
                   (timer_q & ~tmr_clr_wr);
  assign events = {key_bad, rst_req_d, timer_d & ~timer_q};
  assign status_d = events | (status_q & {`ESR_EV_W{~rd_status}});
  assign mask_d = wr_mask ? wd[`ESR_EV_W-1:0] : mask_q;

  always_comb begin
    wstate_d = wstate_q;
    case (wstate_q)
      ESR_W_IDLE: begin
        if (wr_fire) begin
          wstate_d = ESR_W_RESP;
        end
      end
      ESR_W_RESP: begin
        if (s_axi_bready) begin
          wstate_d = ESR_W_IDLE;
        end
      end
      default: wstate_d = ESR_W_IDLE;
    endcase
  end

  always_comb begin
    rstate_d = rstate_q;
    case (rstate_q)
      ESR_R_IDLE: begin
        if (rd_fire) begin
          rstate_d = ESR_R_DATA;
        end
      end
      ESR_R_DATA: begin
        if (s_axi_rready) begin
          rstate_d = ESR_R_IDLE;
        end
      end
      default: rstate_d = ESR_R_IDLE;
    endcase
  end

  // address and data are taken together once both are offered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wstate_q <= ESR_W_IDLE;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ESR_RESP_OKAY;
    end else begin
      wstate_q <= wstate_d;
      awready_q <= (wstate_q == ESR_W_IDLE) & ~awready_q &
                   s_axi_awvalid & s_axi_wvalid;
      wready_q <= (wstate_q == ESR_W_IDLE) & ~awready_q &
                  s_axi_awvalid & s_axi_wvalid;
      bvalid_q <= (wstate_d == ESR_W_RESP);
      if (wr_fire) begin
        bresp_q <= wr_hit ? `ESR_RESP_OKAY : `ESR_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rstate_q <= ESR_R_IDLE;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ESR_RESP_OKAY;
    end else begin
      rstate_q <= rstate_d;
      arready_q <= (rstate_q == ESR_R_IDLE) & ~arready_q & s_axi_arvalid;
      rvalid_q <= (rstate_d == ESR_R_DATA);
      if (rd_fire) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `ESR_RESP_OKAY : `ESR_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_q <= 1'b0;
      rst_req_q <= 1'b0;
      status_q <= `ESR_STATUS_RST;
      mask_q <= `ESR_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      timer_q <= timer_d;
      rst_req_q <= rst_req_d;
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= |(status_d & mask_d);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_index_q <= 6'h00;
      irq_valid_q <= 1'b0;
    end else begin
      irq_valid_q <= (active_num >= `ESR_IRQ_BASE);
      irq_index_q <= (active_num >= `ESR_IRQ_BASE) ?
                     6'(active_num - `ESR_IRQ_BASE) : 6'h00;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign timer_pending = timer_q;
  assign sys_reset_req = rst_req_q;
  assign active_irq_index = irq_index_q;
  assign active_irq_valid = irq_valid_q;
  assign irq = irq_q;

  property p_timer_clear;
    tmr_clr_wr & ~tmr_set_wr & ~core.timer_event |=> !timer_pending;
  endproperty
  a_timer_clear: assert property (p_timer_clear)
    else $error("timer pending survived a clear write");

  property p_state_fields;
    rd_fire & (rd_idx == `ESR_CTRL_STATE_IDX) |=>
      s_axi_rdata[`ESR_TMR_CLR_BIT] == 1'b0 &&
      s_axi_rdata[`ESR_ANY_PEND_BIT] == $past(|core.ext_pending) &&
      s_axi_rdata[5:0] == $past(core.active_number);
  endproperty
  a_state_fields: assert property (p_state_fields)
    else $error("interrupt state read back wrong");

  property p_top_zero;
    !timer_q && ((core.ext_pending & core.ext_enable) == '0) |->
      top_num == 6'h00;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("top pending number not zero when idle");

  property p_top_timer;
    timer_q |-> top_num == `ESR_TIMER_EXC;
  endproperty
  a_top_timer: assert property (p_top_timer)
    else $error("timer not reported as top pending");

  property p_irq_index;
    core.active_number >= `ESR_IRQ_BASE |=> active_irq_valid &&
      active_irq_index + `ESR_IRQ_BASE == $past(core.active_number);
  endproperty
  a_irq_index: assert property (p_irq_index)
    else $error("peripheral index does not match active number");

  property p_key_guard;
    wr_rst_ctrl & (wd[31:`ESR_KEY_LSB] != `ESR_KEY) |=> !sys_reset_req;
  endproperty
  a_key_guard: assert property (p_key_guard)
    else $error("unkeyed write requested a reset");

  property p_reset_req;
    wr_rst_ctrl & key_ok & wd[`ESR_RST_REQ_BIT] |=> sys_reset_req ##1
      !sys_reset_req;
  endproperty
  a_reset_req: assert property (p_reset_req)
    else $error("keyed reset request not raised for one cycle");

  property p_rst_ctrl_read;
    rd_fire & (rd_idx == `ESR_RST_CTRL_IDX) |=>
      s_axi_rdata == {16'h0000, BIG_ENDIAN, 15'h0000};
  endproperty
  a_rst_ctrl_read: assert property (p_rst_ctrl_read)
    else $error("reset control read value wrong");

  property p_state_reserved;
    rd_fire & (rd_idx == `ESR_CTRL_STATE_IDX) |=>
      s_axi_rdata[31:27] == 5'h00 && s_axi_rdata[24:23] == 2'h0 &&
      s_axi_rdata[21:18] == 4'h0 && s_axi_rdata[11:6] == 6'h00;
  endproperty
  a_state_reserved: assert property (p_state_reserved)
    else $error("reserved state bits not zero");

  property p_clear_zero;
    wr_ctrl_state & ~wd[`ESR_TMR_CLR_BIT] & timer_q |=> timer_pending;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("timer pending lost on a write without clear");

  property p_top_peripheral;
    !timer_q && ((core.ext_pending & core.ext_enable) != '0) |->
      top_num >= `ESR_IRQ_BASE &&
      core.ext_pending[5'(top_num - `ESR_IRQ_BASE)] &&
      core.ext_enable[5'(top_num - `ESR_IRQ_BASE)] &&
      ((core.ext_pending & core.ext_enable &
        ((32'h1 << 5'(top_num - `ESR_IRQ_BASE)) - 32'h1)) == '0);
  endproperty
  a_top_peripheral: assert property (p_top_peripheral)
    else $error("top pending number is not the best enabled source");

  property p_key_status;
    key_bad |=> status_q[`ESR_EV_KEYBAD];
  endproperty
  a_key_status: assert property (p_key_status)
    else $error("ignored reset control write not flagged");

  property p_reset_zero;
    wr_rst_ctrl & ~wd[`ESR_RST_REQ_BIT] |=> !sys_reset_req;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("reset requested without the request bit");

  property p_index_none;
    core.active_number < `ESR_IRQ_BASE |=> !active_irq_valid;
  endproperty
  a_index_none: assert property (p_index_none)
    else $error("peripheral index flagged outside a peripheral");

  property p_timer_irq;
    core.timer_event & ~timer_q & mask_q[`ESR_EV_TIMER] & ~wr_mask |=> irq;
  endproperty
  a_timer_irq: assert property (p_timer_irq)
    else $error("unmasked timer event raised no interrupt");

endmodule : esr_ctrl

/* shared/esr_consts.svh */
// constants for the exception state and reset control block
`ifndef ESR_CONSTS_SVH
`define ESR_CONSTS_SVH

// register word indices; byte address is four times the index
`define ESR_CTRL_STATE_IDX 6'h00
`define ESR_RST_CTRL_IDX 6'h01
`define ESR_STATUS_IDX 6'h02
`define ESR_MASK_IDX 6'h03

// interrupt control and state fields
`define ESR_TMR_SET_BIT 26
`define ESR_TMR_CLR_BIT 25
`define ESR_ANY_PEND_BIT 22
`define ESR_TOP_LSB 12
`define ESR_ACTIVE_LSB 0

// reset control fields
`define ESR_KEY_LSB 16
`define ESR_KEY 16'h05FA
`define ESR_ENDIAN_BIT 15
`define ESR_RST_REQ_BIT 2
`define ESR_DBG_CLR_BIT 1

// exception numbering
`define ESR_TIMER_EXC 6'h0F
`define ESR_IRQ_BASE 6'h10
`define ESR_NIRQ 32

// event status bits, mask uses the same layout
`define ESR_EV_W 3
`define ESR_EV_TIMER 0
`define ESR_EV_RST 1
`define ESR_EV_KEYBAD 2
`define ESR_STATUS_RST 3'h0
`define ESR_MASK_RST 3'h0

// bus responses
`define ESR_RESP_OKAY 2'h0
`define ESR_RESP_SLVERR 2'h2

`endif

/* shared/esr_pkg.sv */
// types for the exception state and reset control block
`include "esr_consts.svh"
package esr_pkg;

  // state of the core's exception logic, sampled every cycle
  typedef struct packed {
    logic timer_event;
    logic [5:0] active_number;
    logic [`ESR_NIRQ-1:0] ext_pending;
    logic [`ESR_NIRQ-1:0] ext_enable;
  } esr_core_s;

  typedef enum logic [1:0] {
    ESR_W_IDLE = 2'b01,
    ESR_W_RESP = 2'b10
  } esr_wstate_e;

  typedef enum logic [1:0] {
    ESR_R_IDLE = 2'b01,
    ESR_R_DATA = 2'b10
  } esr_rstate_e;

endpackage : esr_pkg

/* tb/tb_esr_ctrl.sv */
// self-checking bench for the exception state and reset control block
`timescale 1ns/1ps
`include "esr_consts.svh"

module tb_esr_ctrl
  import esr_pkg::*;
  ;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  esr_core_s core = '0;
  logic timer_pending;
  logic [5:0] active_irq_index;
  logic active_irq_valid;
  logic sys_reset_req;
  logic irq;
  int mismatches = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic rst_seen;

  esr_ctrl esr_ctrl_i (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core(core),
    .timer_pending(timer_pending), .active_irq_index(active_irq_index),
    .active_irq_valid(active_irq_valid), .sys_reset_req(sys_reset_req),
    .irq(irq));

  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic give_up();
    mismatches++;
    $display("ERROR %0t: slave gave no answer", $time);
    close_out();
  endtask : give_up

  // the sys_reset_req pulse lands in the response cycle, so watch it there
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    rst_seen = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (sys_reset_req === 1'b1) rst_seen = 1'b1;
      if (bvalid === 1'b1) break;
    end
    if (n == 50) give_up();
    rsp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 50) give_up();
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_read

  task automatic pulse_timer();
    core.timer_event <= 1'b1;
    @(posedge clk);
    core.timer_event <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_timer

  task automatic t_reset_values();
    for (int i = 0; i < 4; i++) begin
      axi_read(8'(4 * i));
      check(rd, 32'h0);
    end
    check(32'({timer_pending, sys_reset_req, irq}), 32'h0);
  endtask : t_reset_values

  task automatic t_timer();
    pulse_timer();
    check(32'(timer_pending), 32'h1);
    axi_read(8'h00);
    check(rd, 32'h0400_F000);
    axi_write(8'h00, 32'h0);
    check(32'(timer_pending), 32'h1);
    axi_write(8'h00, 32'h03BC_0FC0);
    check(32'(timer_pending), 32'h0);
    axi_read(8'h00);
    check(rd, 32'h0);
    axi_write(8'h00, 32'h0400_0000);
    check(32'(timer_pending), 32'h1);
    axi_write(8'h00, 32'h0200_0000);
    check(32'(timer_pending), 32'h0);
    axi_read(8'h08);
    check(rd, 32'h1);
    axi_read(8'h08);
    check(rd, 32'h0);
  endtask : t_timer

  task automatic t_peripheral();
    core.ext_pending <= 32'h0000_0008;
    repeat (2) @(posedge clk);
    axi_read(8'h00);
    check(rd, 32'h0040_0000);
    core.ext_pending <= 32'h0000_0028;
    core.ext_enable <= 32'h0000_0028;
    repeat (2) @(posedge clk);
    axi_read(8'h00);
    check(rd, 32'h0041_3000);
    core.ext_pending <= 32'h0;
    core.ext_enable <= 32'h0;
    repeat (2) @(posedge clk);
    axi_read(8'h00);
    check(rd, 32'h0);
  endtask : t_peripheral

  task automatic t_active();
    logic [5:0] nums [4] = '{6'h13, 6'h2F, 6'h0F, 6'h00};
    foreach (nums[i]) begin
      core.active_number <= nums[i];
      repeat (2) @(posedge clk);
      check(32'(active_irq_valid), 32'(nums[i] >= 6'h10));
      if (nums[i] >= 6'h10) begin
        check(32'(active_irq_index), 32'(nums[i] - 6'h10));
      end
      axi_read(8'h00);
      check(rd, {26'h0, nums[i]});
    end
  endtask : t_active

  task automatic t_reset_ctrl();
    axi_write(8'h04, 32'h05FB_0004);
    check(32'(rst_seen), 32'h0);
    check(32'(rsp), 32'(`ESR_RESP_OKAY));
    // key bytes masked off by the strobes, so the key is missing
    wstrb <= 4'h3;
    axi_write(8'h04, {`ESR_KEY, 16'h0004});
    check(32'(rst_seen), 32'h0);
    wstrb <= 4'hF;
    axi_write(8'h04, {`ESR_KEY, 16'h0004});
    check(32'(rst_seen), 32'h1);
    axi_write(8'h04, {`ESR_KEY, 16'hFFF9});
    check(32'(rst_seen), 32'h0);
    axi_read(8'h04);
    check(rd, 32'h0);
    check(32'(rsp), 32'(`ESR_RESP_OKAY));
    axi_read(8'h08);
    check(rd, 32'h6);
  endtask : t_reset_ctrl

  task automatic t_bus_irq();
    axi_read(8'h10);
    check(32'(rsp), 32'(`ESR_RESP_SLVERR));
    axi_write(8'h10, 32'hFFFF_FFFF);
    check(32'(rsp), 32'(`ESR_RESP_SLVERR));
    axi_write(8'h0C, 32'h1);
    axi_read(8'h0C);
    check(rd, 32'h1);
    check(32'(irq), 32'h0);
    pulse_timer();
    check(32'(irq), 32'h1);
    axi_read(8'h08);
    check(rd, 32'h1);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    axi_write(8'h00, 32'h0200_0000);
    axi_write(8'h0C, 32'h0);
    pulse_timer();
    check(32'(irq), 32'h0);
  endtask : t_bus_irq

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_timer();
    t_peripheral();
    t_active();
    t_reset_ctrl();
    t_bus_irq();
    close_out();
  end
endmodule : tb_esr_ctrl
